// *** tvs_cfg.svh ***
`ifndef TVS_CFG_SVH
`define TVS_CFG_SVH
// system clock rate and the frame rate of the sync
`define TVS_CLK_HZ 250000000
`define TVS_FRAME_HZ 8000
// the two internal bit clock rates
`define TVS_BCLK_2000_HZ 2000000
`define TVS_BCLK_2048_HZ 2048000
// half periods in system clocks, rounded down (shortest time)
`define TVS_HALF_2000 ((`TVS_CLK_HZ / `TVS_BCLK_2000_HZ) / 2)
`define TVS_HALF_2048 ((`TVS_CLK_HZ / `TVS_BCLK_2048_HZ) / 2)
// bit clocks per frame for each internal rate
`define TVS_FRAME_2000 (`TVS_BCLK_2000_HZ / `TVS_FRAME_HZ)
`define TVS_FRAME_2048 (`TVS_BCLK_2048_HZ / `TVS_FRAME_HZ)
// slot geometry
`define TVS_SLOTS 4
`define TVS_NARROW 8
`define TVS_WIDE 16
`define TVS_POS_W 10
// main clock output divider, half period in system clocks
`define TVS_MCLK_HALF 10
`endif

// *** tvs_pkg.sv ***
package tvs_pkg;
  // clocking mode of the port
  typedef enum logic [1:0] {
    TVS_MASTER_INT,
    TVS_MASTER_EXT,
    TVS_SLAVE
  } tvs_mode_t;

  // per-slot setup
  typedef struct packed {
    logic enable;
    logic wide;
    logic [9:0] start;
  } tvs_slot_cfg_t;

  // port-wide setup
  typedef struct packed {
    tvs_mode_t mode;
    logic rate_2048;
    logic long_sync;
    logic mclk_en;
  } tvs_port_cfg_t;

  // one slot's sample in either direction
  typedef struct packed {
    logic [15:0] data;
  } tvs_sample_t;
endpackage

// *** tvs_edge_sync.sv ***
`include "tvs_cfg.svh"
// two-flop synchroniser plus edge finder for one outside level
module tvs_edge_sync (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // raw pin level
  input wire logic pin_in,
  // synchronised level and its edges
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);
  logic meta_reg, meta_next;
  logic sync_reg, sync_next;
  logic last_reg, last_next;

  // next values: first flop feeds only the second
  always_comb begin
    meta_next = pin_in;
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  // register stage
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  // edges seen from the second and third flops only
  assign level_out = sync_reg;
  assign rise_out = sync_reg & ~last_reg;
  assign fall_out = ~sync_reg & last_reg;
endmodule // tvs_edge_sync

// *** tvs_port.sv ***
`include "tvs_cfg.svh"
// Behaviour
// - internal master drives 2/2.048 MHz, 8 kHz sync
// - external-clock master still makes its sync
// - slave takes both clock and sync
// - sync starts frame, at most four slots
// - each slot 8 or 16 bits alone
// - idle bit clocks allowed between slots
// - slot start is offset from sync start
// - lower slot always precedes higher slot (starts are not checked; each slot sits at its own start)
// - each slot enabled on its own
// - long or short sync chosen by setup
// - optional main clock output to codec
module tvs_port #(
  parameter int SLOTS = `TVS_SLOTS,
  parameter int EXT_FRAME = 256
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // configuration
  input wire tvs_pkg::tvs_port_cfg_t port_cfg_in,
  input wire tvs_pkg::tvs_slot_cfg_t [SLOTS-1:0] slot_cfg_in,
  // transmit samples, taken at frame start
  input wire tvs_pkg::tvs_sample_t [SLOTS-1:0] tx_sample_in,
  // bit clock pin, three signals
  input wire logic voice_bit_clock_pin_in,
  output logic voice_bit_clock_pin_out,
  output logic voice_bit_clock_pin_oe_out,
  // frame sync pin, three signals
  input wire logic voice_frame_sync_pin_in,
  output logic voice_frame_sync_pin_out,
  output logic voice_frame_sync_pin_oe_out,
  // serial data
  input wire logic voice_serial_in,
  output logic voice_serial_out,
  // optional codec main clock
  output logic codec_main_clock_out,
  // received samples and status
  output tvs_pkg::tvs_sample_t [SLOTS-1:0] rx_sample_out,
  output logic [SLOTS-1:0] rx_valid_out,
  output logic frame_start_out
);
  // internal bit clock generator
  logic [7:0] div_reg, div_next;
  logic bclk_reg, bclk_next;
  // main clock divider
  logic [7:0] mdiv_reg, mdiv_next;
  logic mclk_reg, mclk_next;
  // synchronised pins
  logic ck_lvl, ck_rise, ck_fall;
  logic fs_lvl, fs_rise, fs_fall;
  logic din_meta_reg, din_reg;
  // pin drive enables, registered so the pins come from flops
  logic clk_oe_reg, clk_oe_next;
  logic sync_oe_reg, sync_oe_next;
  // frame position in bit clocks since sync start
  logic [9:0] pos_reg, pos_next;
  // sync output, serial output and its enable
  logic fs_reg, fs_next;
  logic dout_reg, dout_next;
  logic oe_reg, oe_next;
  logic frame_reg, frame_next;
  // shadow of tx data and rx shift state
  tvs_pkg::tvs_sample_t [SLOTS-1:0] tx_reg, tx_next;
  tvs_pkg::tvs_sample_t [SLOTS-1:0] rx_reg, rx_next;
  logic [SLOTS-1:0] vld_reg, vld_next;
  // decoded edges in the active clock source
  logic master, ext_clk, rise, fall;
  logic [7:0] half;
  logic [9:0] frame_len, first_w;
  logic sync_start;

  // bit count of a slot from its width bit
  function automatic logic [9:0] slot_len(input logic wide);
    slot_len = wide ? 10'(`TVS_WIDE) : 10'(`TVS_NARROW);
  endfunction

  // whether the given slot is enabled and active at a given position
  function automatic logic in_slot(input tvs_pkg::tvs_slot_cfg_t c,
                                   input logic [9:0] p);
    in_slot = c.enable && p >= c.start && p < c.start + slot_len(c.wide);
  endfunction

  tvs_edge_sync u_ck (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(voice_bit_clock_pin_in),
    .level_out(ck_lvl),
    .rise_out(ck_rise),
    .fall_out(ck_fall)
  );

  tvs_edge_sync u_fs (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .pin_in(voice_frame_sync_pin_in),
    .level_out(fs_lvl),
    .rise_out(fs_rise),
    .fall_out(fs_fall)
  );

  // mode decode
  always_comb begin
    master = port_cfg_in.mode != tvs_pkg::TVS_SLAVE;
    ext_clk = port_cfg_in.mode != tvs_pkg::TVS_MASTER_INT;
    half = port_cfg_in.rate_2048 ? 8'(`TVS_HALF_2048)
                                 : 8'(`TVS_HALF_2000);
    // an outside clock must be a multiple of 8k; length is set here
    if (ext_clk)
      frame_len = 10'(EXT_FRAME);
    else if (port_cfg_in.rate_2048)
      frame_len = 10'(`TVS_FRAME_2048);
    else
      frame_len = 10'(`TVS_FRAME_2000);
    first_w = slot_len(slot_cfg_in[0].wide);
  end

  // bit clock source selection; the internal clock is not resynchronised
  assign rise = ext_clk ? ck_rise : (div_reg == half - 8'h01 && !bclk_reg);
  assign fall = ext_clk ? ck_fall : (div_reg == half - 8'h01 && bclk_reg);
  // slave frames start on a sampled sync rise at a bit clock rise
  // the parked reset position starts the first master frame at once
  assign sync_start = master ? (pos_reg == frame_len - 10'h001 ||
                                pos_reg == 10'h3FF)
                             : (fs_lvl && !frame_reg);

  // internal divider and main clock next state
  always_comb begin
    div_next = (div_reg >= half - 8'h01) ? 8'h00 : div_reg + 8'h01;
    bclk_next = (div_reg >= half - 8'h01) ? ~bclk_reg : bclk_reg;
    mdiv_next = (mdiv_reg >= 8'(`TVS_MCLK_HALF - 1)) ? 8'h00
                                                     : mdiv_reg + 8'h01;
    mclk_next = port_cfg_in.mclk_en &&
                ((mdiv_reg >= 8'(`TVS_MCLK_HALF - 1)) ? ~mclk_reg
                                                      : mclk_reg);
    // only the internal master owns the clock pin
    clk_oe_next = port_cfg_in.mode == tvs_pkg::TVS_MASTER_INT;
    // both master modes drive the sync pin, slave listens
    sync_oe_next = master;
  end

  // frame, sync and data next state
  always_comb begin
    pos_next = pos_reg;
    fs_next = fs_reg;
    dout_next = dout_reg;
    oe_next = oe_reg;
    frame_next = frame_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    vld_next = '0;
    if (!master && !fs_lvl)
      frame_next = 1'b0;
    if (rise) begin
      // launch edge: advance position, drive sync and data
      if (sync_start) begin
        pos_next = 10'h000;
        frame_next = 1'b1;
        tx_next = tx_sample_in;
      end else if (pos_reg != 10'h3FF) begin
        pos_next = pos_reg + 10'h001;
      end
      // sync: short is one bit, long spans first slot
      if (master)
        fs_next = sync_start ||
                  (port_cfg_in.long_sync && pos_next < first_w);
      else
        fs_next = 1'b0;
      oe_next = 1'b0;
      dout_next = 1'b0;
      // idle bits between slots keep the line off
      for (int i = 0; i < SLOTS; i++) begin
        if (in_slot(slot_cfg_in[i], pos_next)) begin
          oe_next = 1'b1;
          dout_next = tx_next[i].data[4'(slot_len(slot_cfg_in[i].wide) -
                                    10'h001 - (pos_next -
                                    slot_cfg_in[i].start))];
        end
      end
    end
    if (fall) begin
      // sample edge: shift msb first, flag end of slot
      for (int i = 0; i < SLOTS; i++) begin
        if (in_slot(slot_cfg_in[i], pos_reg)) begin
          rx_next[i].data = {rx_reg[i].data[14:0], din_reg};
          if (pos_reg == slot_cfg_in[i].start +
              slot_len(slot_cfg_in[i].wide) - 10'h001) begin
            vld_next[i] = 1'b1;
            if (!slot_cfg_in[i].wide)
              rx_next[i].data = {8'h00, rx_reg[i].data[6:0], din_reg};
          end
        end
      end
    end
  end

  // registers of every group
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div_reg <= 8'h00;
      bclk_reg <= 1'b0;
      mdiv_reg <= 8'h00;
      mclk_reg <= 1'b0;
      pos_reg <= 10'h3FF;
      fs_reg <= 1'b0;
      dout_reg <= 1'b0;
      oe_reg <= 1'b0;
      frame_reg <= 1'b0;
      tx_reg <= '0;
      rx_reg <= '0;
      vld_reg <= '0;
      din_meta_reg <= 1'b0;
      din_reg <= 1'b0;
      clk_oe_reg <= 1'b0;
      sync_oe_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      bclk_reg <= bclk_next;
      mdiv_reg <= mdiv_next;
      mclk_reg <= mclk_next;
      pos_reg <= pos_next;
      fs_reg <= fs_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      frame_reg <= frame_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      vld_reg <= vld_next;
      din_meta_reg <= voice_serial_in;
      din_reg <= din_meta_reg;
      clk_oe_reg <= clk_oe_next;
      sync_oe_reg <= sync_oe_next;
    end
  end

  // pins and status straight from flops
  assign voice_bit_clock_pin_out = bclk_reg;
  assign voice_bit_clock_pin_oe_out = clk_oe_reg;
  assign voice_frame_sync_pin_out = fs_reg;
  assign voice_frame_sync_pin_oe_out = sync_oe_reg;
  assign voice_serial_out = dout_reg;
  assign codec_main_clock_out = mclk_reg;
  assign rx_sample_out = rx_reg;
  assign rx_valid_out = vld_reg;
  assign frame_start_out = fs_reg;

  // checks on what the port itself drives

  // clock pin enable follows the mode one cycle later
  clk_oe_mode_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !$past(rst_in) |-> voice_bit_clock_pin_oe_out ==
      ($past(port_cfg_in.mode) == tvs_pkg::TVS_MASTER_INT))
    else $error("bit clock enable does not follow the mode");

  // sync pin enable is on in both master modes
  sync_oe_mode_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !$past(rst_in) |-> voice_frame_sync_pin_oe_out ==
      ($past(port_cfg_in.mode) != tvs_pkg::TVS_SLAVE))
    else $error("sync enable does not follow the mode");

  // main clock stays low while it is switched off
  mclk_off_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !$past(port_cfg_in.mclk_en) |-> !codec_main_clock_out)
    else $error("main clock runs while disabled");

  // master position never passes the frame length
  pos_range_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    master && $stable(port_cfg_in) |->
      (pos_reg < frame_len || pos_reg == 10'h3FF))
    else $error("frame position out of range");

  // short sync drops after one bit
  short_sync_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    master && !port_cfg_in.long_sync && rise && !sync_start |=>
      !voice_frame_sync_pin_out)
    else $error("short sync longer than one bit");

  // a slot completes only on a sampling edge
  valid_on_fall_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    |rx_valid_out |-> $past(fall))
    else $error("slot valid without a sampling edge");

  // transmit samples are taken at frame start
  tx_latch_a: assert property (
    @(posedge clk_in) disable iff (rst_in)
    rise && sync_start |=> tx_reg == $past(tx_sample_in))
    else $error("transmit samples not taken at frame start");

  // main scenarios reached
  master_frame_c: cover property (@(posedge clk_in) disable iff (rst_in)
    master && rise && sync_start);
  slave_long_c: cover property (@(posedge clk_in) disable iff (rst_in)
    !master && rise && sync_start && port_cfg_in.long_sync);
  slot_done_c: cover property (@(posedge clk_in) disable iff (rst_in)
    |rx_valid_out);
endmodule // tvs_port

// *** tvs_codec_model.sv ***
// far-side codec: makes bit clock and sync in slave mode, 48 ns bit period
module tvs_codec_model (
  // control from the bench
  input wire logic go_in,
  input wire logic long_in,
  input wire logic [4:0] long_len_in,
  input wire logic [95:0] pattern_in,
  // device serial output
  input wire logic dout_in,
  // bus pins driven by the codec
  output logic bclk_out,
  output logic sync_out,
  output logic din_out,
  // captured device bits, first bit in bit 95
  output logic [95:0] cap_out,
  output logic busy_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // clock stands still low outside frames
  initial begin
    bclk_out = 0;
    sync_out = 0;
    din_out = 0;
    cap_out = '0;
    busy_out = 0;
  end
  // one frame of 96 bit clocks per go pulse, a whole count per frame
  // the bit rate is above the pin range only to keep runs short
  always @(posedge go_in) begin
    busy_out = 1;
    for (int p = 0; p < 96; p++) begin
      din_out = pattern_in[95-p]; // msb first, launched on rise
      sync_out = long_in ? (p < long_len_in) : (p == 0);
      bclk_out = 1; // both clock and sync from this side
      #24;
      bclk_out = 0;
      cap_out[95-p] = dout_in; // take device bit on fall
      #24;
    end
    sync_out = 0;
    // released data line has no pull: show the inverse, not the last bit
    din_out = ~din_out;
    busy_out = 0;
  end
endmodule // tvs_codec_model

// *** tdm_voice_slot_port_tb.sv ***
`include "tvs_cfg.svh"
module tdm_voice_slot_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, rst_in, go, busy, lng, m_bc, m_fs, m_din;
  tvs_pkg::tvs_port_cfg_t pcfg;
  tvs_pkg::tvs_slot_cfg_t [3:0] scfg;
  tvs_pkg::tvs_sample_t [3:0] txs, rxs;
  logic bc_o, bc_oe, fs_o, fs_oe, sd_o;
  logic [95:0] pat, cap;
  logic mck;
  logic [31:0] seed, r;
  int miscompares, cmp_count, n;
  // pin level: device when enabled, else the codec
  wire logic bc_w = bc_oe ? bc_o : m_bc;
  wire logic fs_w = fs_oe ? fs_o : m_fs;
  tvs_port uut (.clk_in(clk_in), .rst_in(rst_in), .port_cfg_in(pcfg),
    .slot_cfg_in(scfg), .tx_sample_in(txs), .voice_bit_clock_pin_in(bc_w),
    .voice_bit_clock_pin_out(bc_o), .voice_bit_clock_pin_oe_out(bc_oe),
    .voice_frame_sync_pin_in(fs_w), .voice_frame_sync_pin_out(fs_o),
    .voice_frame_sync_pin_oe_out(fs_oe), .voice_serial_in(m_din),
    .voice_serial_out(sd_o), .codec_main_clock_out(mck), .rx_sample_out(rxs),
    .rx_valid_out(), .frame_start_out());
  tvs_codec_model codec (.go_in(go), .long_in(lng),
    .long_len_in(scfg[0].wide ? 5'h10 : 5'h08), .pattern_in(pat),
    .dout_in(sd_o), .bclk_out(m_bc), .sync_out(m_fs), .din_out(m_din),
    .cap_out(cap), .busy_out(busy));
  // 250 MHz system clock
  initial begin
    clk_in = 0;
    forever #2 clk_in = ~clk_in;
  end
  // xorshift source, fixed seed
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected word: w bits from st onward, msb first
  function automatic logic [15:0] pick(input logic [95:0] v, input int st,
                                       input int w);
    logic [15:0] q;
    q = '0;
    for (int i = 0; i < w; i++) q = {q[14:0], v[95-st-i]};
    return q;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // bounded wait for a rise of the driven sync, n counts cycles
  task automatic fs_rise();
    logic p;
    n = 1;
    p = fs_o;
    @(posedge clk_in);
    #1;
    while (!(fs_o === 1'b1 && p === 1'b0) && n < 40000) begin
      p = fs_o;
      @(posedge clk_in);
      #1;
      n++;
    end
    if (n >= 40000) begin
      miscompares++;
      final_report;
    end
  endtask
  // one slave frame; tight packs wide slots back to back from zero
  task automatic frame(input logic [3:0] en, input logic tight);
    int pos, w, k;
    pos = tight ? 0 : int'(rnd() % 4);
    for (int s = 0; s < 4; s++) begin
      r = rnd();
      scfg[s].enable = en[s];
      scfg[s].wide = tight | r[0];
      scfg[s].start = 10'(pos); // ascending starts
      txs[s].data = r[31:16];
      pos += (scfg[s].wide ? 16 : 8) + (tight ? 0 : int'(r[3:2]));
    end
    pat = {rnd(), rnd(), rnd()};
    lng = ~lng; // alternate sync formats
    pcfg.long_sync = lng;
    go = 1;
    repeat (2) @(posedge clk_in);
    #1;
    go = 0;
    k = 0;
    while (busy && k < 3000) begin
      @(posedge clk_in);
      k++;
    end
    if (k >= 3000) begin
      miscompares++;
      final_report;
    end
    repeat (40) @(posedge clk_in);
    #1;
    for (int s = 0; s < 4; s++) begin
      if (scfg[s].enable) begin
        w = scfg[s].wide ? 16 : 8;
        chk("rx slot", pick(pat, scfg[s].start, w),
            rxs[s].data & ((1 << w) - 1));
        chk("tx slot", txs[s].data & ((1 << w) - 1),
            pick(cap, scfg[s].start, w));
      end
    end
  endtask
  // main sequence
  initial begin
    seed = 32'h2876;
    miscompares = 0;
    cmp_count = 0;
    rst_in = 1;
    go = 0;
    lng = 0;
    pat = '0;
    scfg = '0;
    txs = '0;
    pcfg = '0;
    pcfg.mode = tvs_pkg::TVS_MASTER_INT;
    pcfg.mclk_en = 1;
    repeat (20) @(posedge clk_in);
    #1;
    rst_in = 0;
    fs_rise();
    fs_rise();
    chk("sync period", 2 * `TVS_HALF_2000 * `TVS_FRAME_2000, n);
    chk("master clk oe", 1, bc_oe);
    pcfg.mode = tvs_pkg::TVS_MASTER_EXT;
    repeat (10) @(posedge clk_in);
    #1;
    chk("ext clk oe", 0, bc_oe);
    chk("ext sync oe", 1, fs_oe);
    pcfg.mode = tvs_pkg::TVS_SLAVE;
    pcfg.mclk_en = 0;
    repeat (10) @(posedge clk_in);
    #1;
    chk("mclk off", 0, mck);
    chk("slave clk oe", 0, bc_oe);
    chk("slave sync oe", 0, fs_oe);
    frame(4'hF, 1);
    frame(4'h2, 0);
    for (int i = 0; i < 6; i++) begin
      r = rnd();
      frame(r[3:0], 0);
    end
    final_report;
  end
endmodule // tdm_voice_slot_port_tb
